// ### sim/cec_assertions.sv
/* Port checks on the comparator event control block.
   Assumes one clock and register reads that are combinational while psel is high. */
`timescale 1ns/100ps
module cec_chk (
  input wire logic pclk, presetn, psel, penable, pwrite, cmp_raw_out, cmp_analog_enable, cmp_ref_select,
  input wire logic deep_stop_mode, cmp_output_pin, cmp_output_pin_oe, cmp_irq,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd_ctrl = psel && !pwrite && paddr == 12'h000;
  a_pin_power: assert property (cmp_output_pin_oe |-> cmp_analog_enable) else $error("pin driven unpowered");
  a_deep_off: assert property (deep_stop_mode |-> !cmp_analog_enable && !cmp_output_pin_oe) else $error("deep on");
  a_sync_depth: assert property (cmp_output_pin_oe && $past(cmp_output_pin_oe, 3)
    |-> cmp_output_pin == $past(cmp_raw_out, 2)) else $error("pin not two stages");
  a_irq_read: assert property (rd_ctrl |-> cmp_irq == (prdata[5] && prdata[4])) else $error("irq level");
  a_live_off: assert property (rd_ctrl && !prdata[7] |-> !prdata[3]) else $error("live bit on");
  a_ref_read: assert property (rd_ctrl |-> cmp_ref_select == prdata[6]) else $error("ref select");
  a_irq_masked: assert property (psel && penable && pwrite && paddr == 12'h000 && !pwdata[4]
    |=> !cmp_irq) else $error("irq unmasked");
  a_reset_clear: assert property (disable iff (1'b0) !presetn
    |-> !cmp_irq && !cmp_output_pin_oe && !cmp_ref_select && !cmp_analog_enable) else $error("reset state");
endmodule : cec_chk
bind cec_comparator_event_control cec_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .cmp_raw_out,
  .cmp_analog_enable, .cmp_ref_select, .deep_stop_mode, .cmp_output_pin, .cmp_output_pin_oe, .cmp_irq,
  .paddr, .pwdata, .prdata);

// ### sim/cec_cmp_model.sv
/* Behavioural analog comparator facing the block.
   Assumes the bench sets both input levels on the rising edge of pclk. */
`timescale 1ns/100ps
module cec_cmp_model (
  input wire logic pclk, cmp_analog_enable, cmp_ref_select, level_pos, level_ref,
  output logic cmp_raw_out
);
  logic junk_q = 1'b0;
  // Unpowered, the output wanders, so a stale level cannot pass for a result.
  always_ff @(posedge pclk) junk_q <= ~junk_q;
  assign cmp_raw_out = cmp_analog_enable ? (cmp_ref_select ? level_ref : level_pos) : junk_q;
endmodule : cec_cmp_model

// ### sim/cec_comparator_event_control_test.sv
/* Self-checking bench for the comparator event control block.
   Assumes an APB slave that raises pready within 20 cycles of penable and the comparator model on the far side. */
`timescale 1ns/100ps
module cec_comparator_event_control_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, deep = 1'b0;
  logic lp = 1'b0, lr = 1'b0, tpin = 1'b0, raw, aen, rsel, opin, ooe, cap, irq, pready, pslverr, se;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int err_total = 0, checks_done = 0;
  always #25 pclk = ~pclk;
  cec_comparator_event_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_raw_out(raw), .cmp_analog_enable(aen), .cmp_ref_select(rsel), .deep_stop_mode(deep),
    .cmp_output_pin(opin), .cmp_output_pin_oe(ooe), .timer_one_channel_zero_pin(tpin),
    .timer_capture_in(cap), .cmp_irq(irq));
  cec_cmp_model u_cmp (.pclk(pclk), .cmp_analog_enable(aen), .cmp_ref_select(rsel), .level_pos(lp),
    .level_ref(lr), .cmp_raw_out(raw));
  task automatic conclude();
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk
  // =========================================================================
  // APB master: the request stands until a rising edge samples pready high; data is taken at that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      conclude();
    end
    {rd, se} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rst();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst
  function automatic logic exp_flag(logic [1:0] m, logic rise);
    return m == 2'b11 || (m == 2'b01) == rise;
  endfunction : exp_flag
  initial begin
    void'($urandom(32'h323E4441));
    rst();
    apb(0, 12'h000, 0);
    chk("ctrl reset", 0, rd[7:0]);
    apb(1, 12'h008, 32'hFF);
    chk("unmapped", 1, se);
    for (int m = 0; m < 4; m++) begin
      apb(1, 12'h000, 32'h90 | m);
      repeat (5) @(posedge pclk);
      apb(1, 12'h000, 32'hB0 | m);
      for (int e = 0; e < 2; e++) begin
        lp <= (e == 0);
        repeat (5) @(posedge pclk);
        chk("irq", exp_flag(m[1:0], e == 0), irq);
        apb(1, 12'h000, 32'h90 | m);
        apb(0, 12'h000, 0);
        chk("ctrl", 32'h90 | m | (exp_flag(m[1:0], e == 0) << 5) | ((e == 0) << 3), rd[7:0]);
        apb(1, 12'h000, 32'hB0 | m);
      end
    end
    apb(1, 12'h000, 32'h83);
    lp <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(0, 12'h000, 0);
    chk("masked", 32'h0AB, {irq, rd[7:0]});
    apb(1, 12'h000, 32'hC4); // the reference buffer is taken to be switched on here
    apb(1, 12'h004, 1);
    repeat (6) begin
      {lr, tpin} <= 2'($urandom);
      repeat (4) @(posedge pclk);
      chk("route pin", {3'b111, lr, lr}, {ooe, rsel, aen, opin, cap});
    end
    apb(1, 12'h004, 0);
    repeat (4) @(posedge pclk);
    chk("unrouted", tpin, cap);
    apb(1, 12'h000, 32'h00);
    apb(0, 12'h000, 0);
    chk("off", 0, {ooe, rd[3]});
    apb(1, 12'h000, 32'h93);
    repeat (5) @(posedge pclk);
    apb(1, 12'h000, 32'hB3);
    deep <= 1'b1;
    repeat (4) begin
      lp <= ~lp;
      repeat (4) @(posedge pclk);
    end
    apb(0, 12'h000, 0);
    chk("deep", 0, {irq, aen, rd[5]});
    deep <= 1'b0;
    rst();
    apb(0, 12'h000, 0);
    chk("wake", 0, rd[7:0]);
    conclude();
  end
endmodule : cec_comparator_event_control_test

// ### verilog/cec_comparator_event_control.sv
/*
  Digital control around an analog voltage comparator: APB registers, input synchroniser,
  edge detection, sticky event flag, interrupt, output pin and timer routing.
  Assumes the analog comparator and power controller sit outside; deep stop wake-up and
  stop exit by reset arrive as presetn.
*/
`timescale 1ns/100ps
module cec_comparator_event_control (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparator
  input wire logic cmp_raw_out,
  output logic cmp_analog_enable,
  output logic cmp_ref_select,
  // Power state
  input wire logic deep_stop_mode,
  // Output pin
  output logic cmp_output_pin,
  output logic cmp_output_pin_oe,
  // Timer routing
  input wire logic timer_one_channel_zero_pin,
  output logic timer_capture_in,
  // Interrupt
  output logic cmp_irq
);

  // ==========================================================================
  // Registers
  logic cmp_module_enable_q;
  logic cmp_ref_select_q;
  logic cmp_event_flag_q;
  logic cmp_irq_enable_q;
  logic cmp_out_pin_enable_q;
  logic [1:0] cmp_event_mode_q;
  logic cmp_to_timer_route_q;
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic pin_sync1_q;
  logic pin_sync2_q;
  logic cmp_live_output;
  logic active;
  logic rise;
  logic fall;
  logic event_hit;
  logic wr_ctrl;
  logic wr_opt;
  logic addr_ok;

  // Wait, light stop and debug halt are not inputs: the block ignores them and runs on.
  // Deep stop gates off the analog enable, live output, edges and pin drive; the reset that follows clears the state.
  assign active = cmp_module_enable_q && !deep_stop_mode;

  // ==========================================================================
  // Bus decode
  assign addr_ok = (paddr == cec_pkg::CEC_CTRL_STATUS_ADDR) || (paddr == cec_pkg::CEC_SYS_OPTION_ADDR);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_ctrl = psel && penable && pwrite && (paddr == cec_pkg::CEC_CTRL_STATUS_ADDR);
  assign wr_opt = psel && penable && pwrite && (paddr == cec_pkg::CEC_SYS_OPTION_ADDR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_module_enable_q <= cec_pkg::CEC_CTRL_RESET[cec_pkg::CEC_MODULE_EN_BIT];
      cmp_ref_select_q <= cec_pkg::CEC_CTRL_RESET[cec_pkg::CEC_REF_SEL_BIT];
      cmp_irq_enable_q <= cec_pkg::CEC_CTRL_RESET[cec_pkg::CEC_IRQ_EN_BIT];
      cmp_out_pin_enable_q <= cec_pkg::CEC_CTRL_RESET[cec_pkg::CEC_OUT_PIN_EN_BIT];
      cmp_event_mode_q <= cec_pkg::CEC_CTRL_RESET[cec_pkg::CEC_MODE_LSB +: 2];
    end else if (wr_ctrl) begin
      cmp_module_enable_q <= pwdata[cec_pkg::CEC_MODULE_EN_BIT];
      cmp_ref_select_q <= pwdata[cec_pkg::CEC_REF_SEL_BIT];
      cmp_irq_enable_q <= pwdata[cec_pkg::CEC_IRQ_EN_BIT];
      cmp_out_pin_enable_q <= pwdata[cec_pkg::CEC_OUT_PIN_EN_BIT];
      cmp_event_mode_q <= pwdata[cec_pkg::CEC_MODE_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_to_timer_route_q <= cec_pkg::CEC_ROUTE_RESET;
    end else if (wr_opt) begin
      cmp_to_timer_route_q <= pwdata[cec_pkg::CEC_ROUTE_BIT];
    end
  end

  // ==========================================================================
  // Synchroniser and edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      pin_sync1_q <= 1'b0;
      pin_sync2_q <= 1'b0;
    end else begin
      sync1_q <= cmp_raw_out;
      sync2_q <= sync1_q;
      prev_q <= cmp_live_output;
      pin_sync1_q <= timer_one_channel_zero_pin;
      pin_sync2_q <= pin_sync1_q;
    end
  end

  // Gating with enable means a disable looks like a falling edge; rise and fall are also gated with active, so none fires.
  assign cmp_live_output = sync2_q && active;
  assign rise = cmp_live_output && !prev_q && active;
  assign fall = !cmp_live_output && prev_q && active;

  always_comb begin
    unique case (cec_pkg::cec_mode_e'(cmp_event_mode_q))
      cec_pkg::CEC_MODE_RISE: event_hit = rise;
      cec_pkg::CEC_MODE_BOTH: event_hit = rise || fall;
      cec_pkg::CEC_MODE_FALL_A,
      cec_pkg::CEC_MODE_FALL_B: event_hit = fall;
    endcase
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_event_flag_q <= cec_pkg::CEC_CTRL_RESET[cec_pkg::CEC_FLAG_BIT];
    end else if (event_hit) begin
      cmp_event_flag_q <= 1'b1;
    end else if (wr_ctrl && pwdata[cec_pkg::CEC_FLAG_BIT]) begin
      cmp_event_flag_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Outputs
  assign cmp_irq = cmp_event_flag_q && cmp_irq_enable_q;
  assign cmp_analog_enable = active;
  assign cmp_ref_select = cmp_ref_select_q;
  assign cmp_output_pin = cmp_live_output;
  assign cmp_output_pin_oe = cmp_out_pin_enable_q && active;
  // The channel pin is cut off entirely while routed.
  assign timer_capture_in = cmp_to_timer_route_q ? cmp_live_output : pin_sync2_q;

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (paddr == cec_pkg::CEC_CTRL_STATUS_ADDR) begin
        prdata[cec_pkg::CEC_MODULE_EN_BIT] = cmp_module_enable_q;
        prdata[cec_pkg::CEC_REF_SEL_BIT] = cmp_ref_select_q;
        prdata[cec_pkg::CEC_FLAG_BIT] = cmp_event_flag_q;
        prdata[cec_pkg::CEC_IRQ_EN_BIT] = cmp_irq_enable_q;
        prdata[cec_pkg::CEC_LIVE_OUT_BIT] = cmp_live_output;
        prdata[cec_pkg::CEC_OUT_PIN_EN_BIT] = cmp_out_pin_enable_q;
        prdata[cec_pkg::CEC_MODE_LSB +: 2] = cmp_event_mode_q;
      end else if (paddr == cec_pkg::CEC_SYS_OPTION_ADDR) begin
        prdata[cec_pkg::CEC_ROUTE_BIT] = cmp_to_timer_route_q;
      end
    end
  end

endmodule : cec_comparator_event_control

// ### verilog/cec_pkg.sv
/*
  Constants for the comparator event control block: register offsets, field positions,
  reset values and event mode encodings.
  Assumes an APB master with 32-bit data and word-aligned register addresses.
*/
// Behaviour
// - Block keeps running in wait mode when module enable was set.
// - Event with interrupt enable set raises the wake-up interrupt in wait.
// - In light stop an enabled block compares exactly as in run mode.
// - In light stop the output pin keeps showing the result when enabled.
// - In light stop an event sets the flag and may wake the processor.
// - Leaving stop by reset returns every control and status bit to reset.
// - Deep stop powers the block down; no events are detected.
// - After deep stop wake-up every bit shows its reset value.
// - In background debug mode the block keeps operating normally.
// - Route bit connects comparator output to timer one channel zero capture.
// - Route bit disconnects the channel zero pin from the timer.
// - Event may be a rising, falling or either edge.
// - A select replaces the external non-inverting input with the reference.
// - Pin enable drives the result on the output pin, else undriven.
// - Mode 00 and 10 falling, 01 rising, 11 either edge.
// - Event flag stays set until software writes one to it.
// - Live output bit reads zero while module enable is clear.
// - Interrupt asserted while flag and interrupt enable are both set.
package cec_pkg;

  // ==========================================================================
  // Register map
  localparam logic [11:0] CEC_CTRL_STATUS_ADDR = 12'h000;
  localparam logic [11:0] CEC_SYS_OPTION_ADDR = 12'h004;

  // ==========================================================================
  // Control and status fields
  localparam int CEC_MODE_LSB = 0;
  localparam int CEC_OUT_PIN_EN_BIT = 2;
  localparam int CEC_LIVE_OUT_BIT = 3;
  localparam int CEC_IRQ_EN_BIT = 4;
  localparam int CEC_FLAG_BIT = 5;
  localparam int CEC_REF_SEL_BIT = 6;
  localparam int CEC_MODULE_EN_BIT = 7;
  localparam int CEC_ROUTE_BIT = 0;

  localparam logic [7:0] CEC_CTRL_RESET = 8'h00;
  localparam logic CEC_ROUTE_RESET = 1'b0;

  // ==========================================================================
  // Event modes
  typedef enum logic [1:0] {
    CEC_MODE_FALL_A = 2'b00,
    CEC_MODE_RISE = 2'b01,
    CEC_MODE_FALL_B = 2'b10,
    CEC_MODE_BOTH = 2'b11
  } cec_mode_e;

endpackage : cec_pkg
